/* File: verilog/sohec_params.svh */
// Constants for the state-of-charge hold and end-of-charge block.
// Assumes a 125 MHz APB clock; word registers at four times the index.
// Contract
// RULE1 - Empty hold keeps SOC above hold percent
// RULE2 - Hold percent counts in half percent steps
// RULE3 - Empty detect at threshold plus margin
// RULE4 - Empty detection releases the empty hold
// RULE5 - Near-full hold caps SOC at 99%
// RULE6 - Hold config resets to 0x1002
// RULE7 - Hold config field layout, top zero
// RULE8 - End of charge needs three conditions
// RULE9 - Relearn full capacity from remaining capacity
// RULE10 - Converge reported SOC to zero at empty
// RULE11 - Hypothetical load query gives predictions
// RULE12 - Host waits before reading hypothetical results
// RULE13 - Host writes 0x0060 for flat chemistry
// RULE14 - Keep-out only used with selector six
// RULE15 - Keep-out lower limit from code
// RULE16 - Keep-out upper limit adds span
// RULE17 - Learn full capacity outside keep-out
// RULE18 - Keep-out register field layout
// RULE19 - Percent registers 1/256 percent unsigned
// RULE20 - Temperature registers signed 1/256 degree
// RULE21 - Current registers signed 1.5625uV
// RULE22 - Capacity 5uVh, voltage 1.25mV/16
`ifndef SOHEC_PARAMS_SVH
`define SOHEC_PARAMS_SVH
// Register indexes
`define SOHEC_IDX_KEEPOUT 10'h0d1
`define SOHEC_IDX_HOLD 10'h0d3
`define SOHEC_IDX_EMPTY_THR 10'h03a
`define SOHEC_IDX_FULLTHR 10'h013
`define SOHEC_IDX_ICHG 10'h01e
`define SOHEC_IDX_MODEL 10'h0db
`define SOHEC_IDX_CFG2 10'h0bb
`define SOHEC_IDX_MISC 10'h02b
`define SOHEC_IDX_HYPLOAD 10'h004
`define SOHEC_IDX_SOC 10'h006
`define SOHEC_IDX_TEMP 10'h008
`define SOHEC_IDX_FULLCAP 10'h010
`define SOHEC_IDX_HYPTTE 10'h0dd
`define SOHEC_IDX_HYPSOC 10'h0ce
`define SOHEC_IDX_HYPCAP 10'h0cc
`define SOHEC_IDX_STATUS 10'h0b0
// Reset values
`define SOHEC_RST_KEEPOUT 16'h479e
`define SOHEC_RST_HOLD 16'h1002
`define SOHEC_RST_EMPTY_THR 16'h8ca0
`define SOHEC_RST_FULLTHR 16'h5f05
`define SOHEC_RST_ICHG 16'h0640
`define SOHEC_RST_MODEL 16'h0000
`define SOHEC_RST_CFG2 16'h0000
`define SOHEC_RST_MISC 16'h0000
// Fields and scales
`define SOHEC_NEAR_EN_BIT 12
`define SOHEC_HYP_EN_BIT 2
`define SOHEC_FLAT_ID 4'h6
`define SOHEC_SOC_99 16'h6300
`define SOHEC_KO_BASE 17'h08000
`define SOHEC_CTE_WIN 17'h00200
`define SOHEC_CTE_SHIFT 5
`define SOHEC_DIV_STEPS 5'd27
`endif

/* File: verilog/sohec_pkg.sv */
// Types shared by the state-of-charge hold block.
// Assumes the params header supplies all numeric constants.
`default_nettype none
package sohec_pkg;
  // Measurement bundle from the gauge engine, same clock
  typedef struct packed {
    logic valid;
    logic [15:0] cell_v;
    logic [15:0] avg_v;
    logic [15:0] volt_soc;
    logic [15:0] soc_raw;
    logic [15:0] rep_cap;
    logic signed [15:0] cur;
    logic signed [15:0] avg_cur;
    logic signed [15:0] temp;
  } sohec_meas_s;
  // APB request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sohec_apb_req_s;
  // APB answer
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sohec_apb_rsp_s;
  typedef enum logic {SOHEC_DIV_IDLE, SOHEC_DIV_RUN} sohec_div_e;
endpackage
`default_nettype wire

/* File: verilog/sohec_top.sv */
// State-of-charge shaping: empty hold, near-full hold, end of charge.
// Assumes measurements arrive on pclk with a one-cycle valid strobe.
`include "sohec_params.svh"
`default_nettype none
module sohec_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire sohec_pkg::sohec_apb_req_s apb_req,
  output sohec_pkg::sohec_apb_rsp_s apb_rsp,
  // Gauge engine
  input wire sohec_pkg::sohec_meas_s meas,
  // Results
  output logic [15:0] reported_soc,
  output logic [15:0] reported_full_capacity,
  output logic empty_detected,
  output logic full_qualified
);
  import sohec_pkg::*;

  // Configuration registers
  logic [15:0] keepout_reg;
  logic [12:0] hold_reg;
  logic [15:0] empty_thr_reg;
  logic [15:0] fullthr_reg;
  logic signed [15:0] ichg_reg;
  logic [15:0] model_reg;
  logic [15:0] cfg2_reg;
  logic [3:0] misc_reg;
  logic signed [15:0] hyp_load_reg;
  // State registers
  logic [15:0] rep_soc_reg;
  logic [15:0] fullcap_reg;
  logic empty_det_reg;
  logic full_qual_reg;
  logic learn_reg;
  logic [15:0] temp_reg;
  logic [15:0] hyp_tte_reg;
  logic [15:0] hyp_soc_reg;
  logic [15:0] hyp_cap_reg;
  logic hyp_done_reg;
  sohec_div_e div_state_reg;
  logic [26:0] quo_reg;
  logic [16:0] rem_reg;
  logic [15:0] dvsr_reg;
  logic [4:0] div_cnt_reg;
  // Bus registers
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  // Strictly inside the termination band, both bounds open
  function automatic logic in_band(input logic signed [15:0] i,
                                   input logic signed [15:0] t);
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    lo = 18'(t) >>> 3;
    hi = 18'(t) + (18'(t) >>> 2);
    in_band = (18'(i) > lo) && (18'(i) < hi);
  endfunction

  function automatic logic [9:0] reg_idx(input logic [11:0] a);
    reg_idx = a[11:2];
  endfunction

  // Bus phases: one wait state, then the completing edge
  logic access;
  logic complete;
  logic wr_en;
  logic [9:0] idx;
  assign access = apb_req.psel && apb_req.penable;
  assign complete = access && pready_reg;
  assign wr_en = complete && apb_req.pwrite;
  assign idx = reg_idx(apb_req.paddr);

  // Derived levels
  logic [16:0] empty_lvl;
  logic [15:0] hold_lvl;
  logic [16:0] ko_lo;
  logic [16:0] ko_hi;
  logic flat_mode;
  logic in_keepout;
  logic eoc;
  logic charging;
  logic discharging;
  logic [15:0] step;
  assign empty_lvl = 17'(empty_thr_reg) + {3'h0, hold_reg[11:5], 7'h00}; // RULE3 RULE22
  assign hold_lvl = {4'h0, hold_reg[4:0], 7'h00}; // RULE2 RULE19
  assign ko_lo = `SOHEC_KO_BASE + {2'h0, keepout_reg[15:7], 6'h00}; // RULE15 RULE18
  assign ko_hi = ko_lo + {5'h00, keepout_reg[6:0], 5'h00}; // RULE16 RULE18
  assign flat_mode = (model_reg[7:4] == `SOHEC_FLAT_ID); // RULE14
  // Window compares only mean something for the flat chemistry
  assign in_keepout = flat_mode && (17'(meas.avg_v) >= ko_lo) &&
                      (17'(meas.avg_v) <= ko_hi); // RULE14 RULE17
  assign eoc = (meas.volt_soc > fullthr_reg) && in_band(meas.cur, ichg_reg) &&
               in_band(meas.avg_cur, ichg_reg); // RULE8 RULE21
  assign charging = (meas.cur > 16'sh0000);
  assign discharging = (meas.cur < 16'sh0000);
  assign step = {12'h000, misc_reg} + 16'h0001;

  // Reported SOC shaping chain
  logic [16:0] cte_diff;
  logic [15:0] soc_cte;
  logic [15:0] soc_hold;
  logic [15:0] soc_next;
  always_comb begin
    cte_diff = 17'(meas.avg_v) - 17'(empty_thr_reg);
    soc_cte = meas.soc_raw;
    // Slope pinned so that zero coincides with empty voltage
    if (meas.avg_v <= empty_thr_reg) begin
      soc_cte = 16'h0000; // RULE10
    end else if (cte_diff < `SOHEC_CTE_WIN) begin
      if (16'(cte_diff << `SOHEC_CTE_SHIFT) < meas.soc_raw) begin
        soc_cte = 16'(cte_diff << `SOHEC_CTE_SHIFT); // RULE10
      end
    end
    soc_hold = soc_cte;
    // Floor lifts only until empty is detected
    if (!empty_det_reg && (soc_cte < hold_lvl)) begin
      soc_hold = hold_lvl; // RULE1 RULE4
    end
    soc_next = soc_hold;
    if (hold_reg[`SOHEC_NEAR_EN_BIT] && charging && !full_qual_reg &&
        (soc_hold > `SOHEC_SOC_99)) begin
      soc_next = `SOHEC_SOC_99; // RULE5
    end
  end

  // Configuration register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keepout_reg <= `SOHEC_RST_KEEPOUT;
      hold_reg <= 13'(`SOHEC_RST_HOLD); // RULE6
      empty_thr_reg <= `SOHEC_RST_EMPTY_THR;
      fullthr_reg <= `SOHEC_RST_FULLTHR;
      ichg_reg <= `SOHEC_RST_ICHG;
      model_reg <= `SOHEC_RST_MODEL;
      cfg2_reg <= `SOHEC_RST_CFG2;
      misc_reg <= 4'(`SOHEC_RST_MISC);
      hyp_load_reg <= 16'sh0000;
    end else if (wr_en) begin
      if (idx == `SOHEC_IDX_KEEPOUT) begin
        keepout_reg <= apb_req.pwdata[15:0]; // RULE18
      end else if (idx == `SOHEC_IDX_HOLD) begin
        hold_reg <= apb_req.pwdata[12:0]; // RULE7
      end else if (idx == `SOHEC_IDX_EMPTY_THR) begin
        empty_thr_reg <= apb_req.pwdata[15:0];
      end else if (idx == `SOHEC_IDX_FULLTHR) begin
        fullthr_reg <= apb_req.pwdata[15:0];
      end else if (idx == `SOHEC_IDX_ICHG) begin
        ichg_reg <= apb_req.pwdata[15:0];
      end else if (idx == `SOHEC_IDX_MODEL) begin
        model_reg <= apb_req.pwdata[15:0]; // RULE13
      end else if (idx == `SOHEC_IDX_CFG2) begin
        cfg2_reg <= apb_req.pwdata[15:0];
      end else if (idx == `SOHEC_IDX_MISC) begin
        misc_reg <= apb_req.pwdata[3:0];
      end else if (idx == `SOHEC_IDX_HYPLOAD) begin
        hyp_load_reg <= apb_req.pwdata[15:0]; // RULE11
      end
    end
  end

  // Empty detection; a new crossing beats the recharge clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_det_reg <= 1'b0;
    end else if (meas.valid && (17'(meas.cell_v) <= empty_lvl)) begin
      empty_det_reg <= 1'b1; // RULE3
    end else if (meas.valid && charging) begin
      empty_det_reg <= 1'b0;
    end
  end

  // Full qualification, dropped once discharge starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_qual_reg <= 1'b0;
    end else if (meas.valid && eoc) begin
      full_qual_reg <= 1'b1; // RULE8
    end else if (meas.valid && discharging) begin
      full_qual_reg <= 1'b0;
    end
  end

  // Reported SOC and temperature follow each measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_soc_reg <= 16'h0000;
      temp_reg <= 16'h0000;
    end else if (meas.valid) begin
      rep_soc_reg <= soc_next; // RULE19
      temp_reg <= meas.temp; // RULE20
    end
  end

  // Capacity learning; flat OCV region gives a false full point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      learn_reg <= 1'b0;
      fullcap_reg <= 16'h0000;
    end else if (meas.valid) begin
      if (eoc && !in_keepout) begin
        learn_reg <= 1'b1; // RULE17
      end else if (fullcap_reg == meas.rep_cap) begin
        learn_reg <= 1'b0;
      end
      // Learning pauses inside the window, even once started
      if (learn_reg && !in_keepout) begin // RULE17
        if (fullcap_reg < meas.rep_cap) begin
          fullcap_reg <= meas.rep_cap; // RULE9 RULE22
        end else if (fullcap_reg - meas.rep_cap > step) begin
          fullcap_reg <= fullcap_reg - step; // RULE9
        end else begin
          fullcap_reg <= meas.rep_cap;
        end
      end
    end
  end

  // Hypothetical load: serial divide keeps area small, costs 27 cycles
  logic [16:0] rem_shift;
  logic hyp_start;
  assign rem_shift = {rem_reg[15:0], quo_reg[26]};
  assign hyp_start = (div_state_reg == SOHEC_DIV_IDLE) && meas.valid &&
                     cfg2_reg[`SOHEC_HYP_EN_BIT] &&
                     (hyp_load_reg < 16'sh0000); // RULE11
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_state_reg <= SOHEC_DIV_IDLE;
      quo_reg <= 27'h0;
      rem_reg <= 17'h0;
      dvsr_reg <= 16'h0;
      div_cnt_reg <= 5'h0;
      hyp_tte_reg <= 16'h0;
      hyp_soc_reg <= 16'h0;
      hyp_cap_reg <= 16'h0;
      hyp_done_reg <= 1'b0;
    end else begin
      hyp_done_reg <= 1'b0;
      case (div_state_reg)
        SOHEC_DIV_IDLE: begin
          if (hyp_start) begin
            quo_reg <= {meas.rep_cap, 11'h000};
            rem_reg <= 17'h0;
            dvsr_reg <= 16'(-hyp_load_reg);
            div_cnt_reg <= `SOHEC_DIV_STEPS;
            hyp_soc_reg <= rep_soc_reg; // RULE11
            hyp_cap_reg <= meas.rep_cap;
            div_state_reg <= SOHEC_DIV_RUN;
          end
        end
        SOHEC_DIV_RUN: begin
          if (rem_shift >= 17'(dvsr_reg)) begin
            rem_reg <= rem_shift - 17'(dvsr_reg);
            quo_reg <= {quo_reg[25:0], 1'b1};
          end else begin
            rem_reg <= rem_shift;
            quo_reg <= {quo_reg[25:0], 1'b0};
          end
          div_cnt_reg <= div_cnt_reg - 5'd1;
          if (div_cnt_reg == 5'd1) begin
            div_state_reg <= SOHEC_DIV_IDLE;
            hyp_done_reg <= 1'b1;
          end
        end
        default: div_state_reg <= SOHEC_DIV_IDLE;
      endcase
      // Saturate time to empty in 5.625 s units
      if (hyp_done_reg) begin
        hyp_tte_reg <= (quo_reg[26:16] != 11'h0) ? 16'hffff : quo_reg[15:0]; // RULE11
      end
    end
  end

  // Read decode
  logic [15:0] rd_data;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 16'h0000;
    if (idx == `SOHEC_IDX_KEEPOUT) begin
      rd_data = keepout_reg;
    end else if (idx == `SOHEC_IDX_HOLD) begin
      rd_data = {3'h0, hold_reg}; // RULE7
    end else if (idx == `SOHEC_IDX_EMPTY_THR) begin
      rd_data = empty_thr_reg;
    end else if (idx == `SOHEC_IDX_FULLTHR) begin
      rd_data = fullthr_reg;
    end else if (idx == `SOHEC_IDX_ICHG) begin
      rd_data = ichg_reg;
    end else if (idx == `SOHEC_IDX_MODEL) begin
      rd_data = model_reg;
    end else if (idx == `SOHEC_IDX_CFG2) begin
      rd_data = cfg2_reg;
    end else if (idx == `SOHEC_IDX_MISC) begin
      rd_data = {12'h000, misc_reg};
    end else if (idx == `SOHEC_IDX_HYPLOAD) begin
      rd_data = hyp_load_reg;
    end else if (idx == `SOHEC_IDX_SOC) begin
      rd_data = rep_soc_reg;
    end else if (idx == `SOHEC_IDX_TEMP) begin
      rd_data = temp_reg;
    end else if (idx == `SOHEC_IDX_FULLCAP) begin
      rd_data = fullcap_reg;
    end else if (idx == `SOHEC_IDX_HYPTTE) begin
      rd_data = hyp_tte_reg;
    end else if (idx == `SOHEC_IDX_HYPSOC) begin
      rd_data = hyp_soc_reg;
    end else if (idx == `SOHEC_IDX_HYPCAP) begin
      rd_data = hyp_cap_reg;
    end else if (idx == `SOHEC_IDX_STATUS) begin
      rd_data = {11'h000, in_keepout, learn_reg, div_state_reg == SOHEC_DIV_RUN,
                 full_qual_reg, empty_det_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Bus answer: ready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= access && !pready_reg;
      if (access && !pready_reg) begin
        pslverr_reg <= !rd_hit;
        prdata_reg <= (rd_hit && !apb_req.pwrite) ? {16'h0000, rd_data} : 32'h0;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign apb_rsp.pready = pready_reg;
  assign apb_rsp.pslverr = pslverr_reg;
  assign apb_rsp.prdata = prdata_reg;
  assign reported_soc = rep_soc_reg;
  assign reported_full_capacity = fullcap_reg;
  assign empty_detected = empty_det_reg;
  assign full_qualified = full_qual_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_hold_floor: assert property (meas.valid && !empty_det_reg && !charging |=> // RULE1
    rep_soc_reg >= $past(hold_lvl)) else $error("empty hold floor broken");
  chk_empty_detect: assert property (meas.valid && 17'(meas.cell_v) <= empty_lvl |=> // RULE3
    empty_det_reg) else $error("empty not detected");
  chk_near_full_cap: assert property (meas.valid && hold_reg[`SOHEC_NEAR_EN_BIT] && // RULE5
    charging && !full_qual_reg |=> rep_soc_reg <= `SOHEC_SOC_99)
    else $error("near-full cap exceeded");
  chk_eoc_qualify: assert property (meas.valid && eoc |=> full_qual_reg) // RULE8
    else $error("end of charge missed");
  chk_cap_raise: assert property (meas.valid && learn_reg && !in_keepout && // RULE9
    fullcap_reg < meas.rep_cap |=> fullcap_reg == $past(meas.rep_cap))
    else $error("full capacity not raised");
  chk_cte_zero: assert property (meas.valid && meas.avg_v <= empty_thr_reg && // RULE10
    empty_det_reg |=> rep_soc_reg == 16'h0000) else $error("not zero at empty");
  chk_keepout_only6: assert property (meas.valid && eoc && !flat_mode |=> learn_reg) // RULE14
    else $error("keep-out used outside flat mode");
  chk_keepout_learn: assert property (meas.valid && in_keepout && !learn_reg |=> // RULE17
    !learn_reg) else $error("learning inside keep-out");
  chk_keepout_hold: assert property (meas.valid && in_keepout |=> // RULE17
    $stable(fullcap_reg)) else $error("full capacity moved inside keep-out");
  chk_hold_read_zero: assert property (complete && !apb_req.pwrite && // RULE7
    idx == `SOHEC_IDX_HOLD |-> prdata_reg[31:13] == 19'h0)
    else $error("hold upper bits not zero");
  chk_hyp_result: assert property (hyp_start |-> ##[28:29] hyp_done_reg) // RULE11
    else $error("hypothetical result late");

  cov_eoc_learn: cover property (meas.valid && eoc && !in_keepout ##1 learn_reg);
  cov_hold_release: cover property (!empty_det_reg ##1 empty_det_reg);
  cov_near_full: cover property (meas.valid && soc_next == `SOHEC_SOC_99);
  cov_hyp_done: cover property (hyp_done_reg);
endmodule
`default_nettype wire

/* File: verification/sohec_top_tb.sv */
// Self-checking bench for the state-of-charge hold block.
// Assumes APB answers with a registered pready and outputs move one cycle after meas.valid.
`include "sohec_params.svh"
`default_nettype none
module sohec_top_tb;
  import sohec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  sohec_apb_req_s apb_req;
  sohec_apb_rsp_s apb_rsp;
  sohec_meas_s meas;
  sohec_meas_s m;
  logic [15:0] reported_soc;
  logic [15:0] reported_full_capacity;
  logic empty_detected;
  logic full_qualified;
  int err_count;
  int checked;
  logic [31:0] seed;
  logic [32:0] qa[$];
  logic [18:0] qm[$];
  logic mv_d = 1'b0;
  logic [18:0] e;
  logic [32:0] ea;
  logic [15:0] cur_t[4] = '{16'h00c8, 16'h07d0, 16'h03e8, 16'h03e8};
  logic [15:0] avg_t[4] = '{16'h03e8, 16'h03e8, 16'h00c8, 16'h07d0};

  sohec_top i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .meas(meas),
    .reported_soc(reported_soc),
    .reported_full_capacity(reported_full_capacity),
    .empty_detected(empty_detected),
    .full_qualified(full_qualified)
  );

  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Galois-free shift register, cheap and repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done;
    begin
      if (err_count == 0 && checked > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask

  task automatic cmp_apb(input logic [32:0] got, input logic [32:0] exp);
    begin
      checked++;
      if (got !== exp) begin
        err_count++;
        $display("[FAIL] %0t apb got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task automatic cmp_meas(input logic [17:0] got, input logic [17:0] exp);
    begin
      checked++;
      if (got !== exp) begin
        err_count++;
        $display("[FAIL] %0t meas got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer; reads note their expected answer first
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] d,
                     input logic [16:0] exp);
    int n;
    begin
      n = 0;
      if (!wr) qa.push_back({exp[16], 16'h0000, exp[15:0]});
      @(posedge pclk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr;
      apb_req.paddr <= {idx, 2'b00};
      apb_req.pwdata <= {16'h0000, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      @(posedge pclk);
      while (apb_rsp.pready !== 1'b1 && n < 50) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 50) err_count++;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, 17'h00000);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [15:0] d, input logic err);
    apb(1'b0, idx, 16'h0000, {err, d});
  endtask

  // One measurement strobe; soc is compared only when chk is set
  task automatic send(input logic [15:0] soc, input logic chk, input logic emp,
                      input logic full);
    begin
      qm.push_back({chk, emp, full, soc});
      seed = lfsr(seed);
      m.temp = seed[15:0];
      m.valid = 1'b1;
      @(posedge pclk);
      meas <= m;
      @(posedge pclk);
      meas.valid <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // APB read answers against the oldest note
  always @(posedge pclk) begin
    if (presetn && apb_rsp.pready === 1'b1 && !apb_req.pwrite) begin
      if (qa.size() == 0) begin
        err_count++;
      end else begin
        ea = qa.pop_front();
        cmp_apb({apb_rsp.pslverr, apb_rsp.prdata}, ea);
        // Output pin must agree with the register view
        if (apb_req.paddr[11:2] == `SOHEC_IDX_FULLCAP) begin
          cmp_apb({17'h00000, reported_full_capacity}, ea);
        end
      end
    end
  end

  // Outputs settle one edge after the strobe edge
  always @(posedge pclk) begin
    if (mv_d) begin
      if (qm.size() == 0) begin
        err_count++;
      end else begin
        e = qm.pop_front();
        cmp_meas({empty_detected, full_qualified, e[18] ? reported_soc : e[15:0]}, e[17:0]);
      end
    end
    mv_d <= presetn && meas.valid;
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done;
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    meas = '0;
    m = '0;
    err_count = 0;
    checked = 0;
    seed = 32'h5696;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SOHEC_IDX_KEEPOUT, 16'h479e, 1'b0);
    rd(`SOHEC_IDX_HOLD, 16'h1002, 1'b0);
    rd(10'h3ff, 16'h0000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(`SOHEC_IDX_HOLD, seed[15:0]);
      rd(`SOHEC_IDX_HOLD, seed[15:0] & 16'h1fff, 1'b0);
      wr(`SOHEC_IDX_KEEPOUT, seed[31:16]);
      rd(`SOHEC_IDX_KEEPOUT, seed[31:16], 1'b0);
    end
    wr(`SOHEC_IDX_KEEPOUT, 16'h479e);
    // Margin 10 counts, floor 6 percent; detect point 0x8ca0 + 0x500
    wr(`SOHEC_IDX_HOLD, 16'h114c);
    m.avg_v = 16'ha500;
    m.cell_v = 16'ha000;
    m.volt_soc = 16'h0200;
    m.soc_raw = 16'h0200;
    m.rep_cap = 16'h1000;
    m.cur = 16'hff9c;
    m.avg_cur = 16'hff9c;
    send(16'h0600, 1'b1, 1'b0, 1'b0);
    m.soc_raw = 16'h0900;
    send(16'h0900, 1'b1, 1'b0, 1'b0);
    m.soc_raw = 16'h0200;
    m.cell_v = 16'h91a1;
    send(16'h0600, 1'b1, 1'b0, 1'b0);
    m.cell_v = 16'h91a0;
    send(16'h0000, 1'b0, 1'b1, 1'b0);
    m.cell_v = 16'ha000;
    send(16'h0200, 1'b1, 1'b1, 1'b0);
    m.avg_v = 16'h8ca0;
    m.soc_raw = 16'h3000;
    send(16'h0000, 1'b1, 1'b1, 1'b0);
    m.avg_v = 16'h8cb0;
    send(16'h0200, 1'b1, 1'b1, 1'b0);
    // Charging: cap at 99 percent only while enabled
    m.avg_v = 16'ha500;
    m.cur = 16'h0064;
    m.avg_cur = 16'h0064;
    m.soc_raw = 16'h6400;
    send(16'h6300, 1'b1, 1'b0, 1'b0);
    wr(`SOHEC_IDX_HOLD, 16'h014c);
    send(16'h6400, 1'b1, 1'b0, 1'b0);
    wr(`SOHEC_IDX_HOLD, 16'h114c);
    // Current band edges are exclusive; threshold 0x0640 gives 200..2000
    m.volt_soc = 16'h5f06;
    for (int i = 0; i < 4; i++) begin
      m.cur = cur_t[i];
      m.avg_cur = avg_t[i];
      send(16'h6300, 1'b1, 1'b0, 1'b0);
    end
    m.cur = 16'h03e8;
    m.avg_cur = 16'h03e8;
    m.volt_soc = 16'h5f05;
    send(16'h6300, 1'b1, 1'b0, 1'b0);
    m.volt_soc = 16'h5f06;
    m.cur = 16'h00c9;
    m.avg_cur = 16'h07cf;
    send(16'h0000, 1'b0, 1'b0, 1'b1);
    // Selector 0: keep-out ignored though avg_v sits inside it
    repeat (3) send(16'h6400, 1'b1, 1'b0, 1'b1);
    rd(`SOHEC_IDX_FULLCAP, 16'h1000, 1'b0);
    wr(`SOHEC_IDX_MISC, 16'h000f);
    m.rep_cap = 16'h0f00;
    repeat (20) send(16'h6400, 1'b1, 1'b0, 1'b1);
    rd(`SOHEC_IDX_FULLCAP, 16'h0f00, 1'b0);
    // Flat chemistry: window 0xa3c0..0xa780 inclusive blocks learning
    wr(`SOHEC_IDX_MODEL, 16'h0060);
    m.rep_cap = 16'h1100;
    m.avg_v = 16'ha780;
    repeat (3) send(16'h6400, 1'b1, 1'b0, 1'b1);
    rd(`SOHEC_IDX_FULLCAP, 16'h0f00, 1'b0);
    m.avg_v = 16'ha3c0;
    repeat (3) send(16'h6400, 1'b1, 1'b0, 1'b1);
    rd(`SOHEC_IDX_FULLCAP, 16'h0f00, 1'b0);
    m.avg_v = 16'ha781;
    repeat (3) send(16'h6400, 1'b1, 1'b0, 1'b1);
    rd(`SOHEC_IDX_FULLCAP, 16'h1100, 1'b0);
    // Hypothetical load: 0x1100 * 2048 / 2048, then saturation
    wr(`SOHEC_IDX_CFG2, 16'h0004);
    wr(`SOHEC_IDX_HYPLOAD, 16'hf800);
    send(16'h6400, 1'b1, 1'b0, 1'b1);
    repeat (40) @(posedge pclk);
    rd(`SOHEC_IDX_HYPTTE, 16'h1100, 1'b0);
    wr(`SOHEC_IDX_HYPLOAD, 16'hffff);
    send(16'h6400, 1'b1, 1'b0, 1'b1);
    repeat (40) @(posedge pclk);
    rd(`SOHEC_IDX_HYPTTE, 16'hffff, 1'b0);
    rd(`SOHEC_IDX_HYPSOC, 16'h6400, 1'b0);
    rd(`SOHEC_IDX_HYPCAP, 16'h1100, 1'b0);
    // Read-only percent register ignores writes
    wr(`SOHEC_IDX_SOC, 16'h1234);
    rd(`SOHEC_IDX_SOC, 16'h6400, 1'b0);
    rd(`SOHEC_IDX_TEMP, m.temp, 1'b0);
    // Full qualified and learning set, outside the window
    rd(`SOHEC_IDX_STATUS, 16'h000a, 1'b0);
    repeat (4) @(posedge pclk);
    if (qa.size() != 0 || qm.size() != 0) err_count++;
    test_done;
  end
endmodule
`default_nettype wire
